// file: design/pwm_input_measurement_unit.v
// apb measurement unit for pwm inputs, one result word per channel
`timescale 1ns/1ps
`include "pwm_meas_defines.vh"
module pwm_input_measurement_unit #(
    parameter CHANNELS = 24
) (
    input  wire                clock,
    input  wire                reset_n,
    input  wire [CHANNELS-1:0] pwm_in,
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [`ADDR_W-1:0]  paddr,
    input  wire [31:0]         pwdata,
    output reg                 pready,
    output reg  [31:0]         prdata,
    output reg                 pslverr
);
    localparam TICK_CYC = (`TICK_NS + `CLK_NS - 1) / `CLK_NS;
    localparam [31:0] TICK_LAST = TICK_CYC - 1;
    localparam [47:0] FREQ_NUM = `NS_PER_S / `TICK_NS;

    reg  [31:0]            tick_cnt_reg;
    reg  [31:0]            now_reg;
    reg  [31:0]            stamp_reg;
    reg  [CHANNELS-1:0]    level_reg;
    wire                   tick;
    wire                   bus_req;
    wire                   bus_wr;
    wire                   acq;
    wire [7:0]             ch_idx;
    wire                   ch_sel;
    wire [1:0]             ch_ofs;
    wire [32*CHANNELS-1:0] cfg_flat;
    wire [32*CHANNELS-1:0] tout_flat;
    wire [32*CHANNELS-1:0] dflt_flat;
    wire [32*CHANNELS-1:0] res_flat;
    reg  [31:0]            rd_data;
    reg                    rd_err;

    // 20 ns time base shared by every channel
    assign tick = (tick_cnt_reg == TICK_LAST);

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_reg <= 32'h00000000;
            now_reg      <= 32'h00000000;
        end else begin
            tick_cnt_reg <= tick ? 32'h00000000 : tick_cnt_reg + 32'h1;
            if (tick) begin
                now_reg <= now_reg + 32'h1;
            end
        end
    end

    // one wait state so prdata can come from a flop
    assign bus_req = psel & penable & ~pready;
    assign bus_wr  = psel & penable & pready & pwrite;
    assign ch_idx  = paddr[11:4] - `CH_BASE_IDX;
    assign ch_sel  = (paddr[11:4] >= `CH_BASE_IDX) &&
                     ({24'h000000, ch_idx} < CHANNELS);
    assign ch_ofs  = paddr[3:2];
    assign acq     = bus_wr & (paddr == `OFS_CTRL) & pwdata[`CTRL_ACQ_BIT];

    always @* begin
        rd_data = 32'h00000000;
        rd_err  = 1'b0;
        if (ch_sel) begin
            case (ch_ofs)
                `CH_CFG:    rd_data = cfg_flat[ch_idx*32 +: 32];
                `CH_TOUT:   rd_data = tout_flat[ch_idx*32 +: 32];
                `CH_DFLT:   rd_data = dflt_flat[ch_idx*32 +: 32];
                `CH_RESULT: rd_data = res_flat[ch_idx*32 +: 32];
                default:    rd_err  = 1'b1;
            endcase
        end else begin
            case (paddr)
                `OFS_CTRL:  rd_data = 32'h00000000;
                `OFS_STAMP: rd_data = stamp_reg;
                `OFS_LEVEL: rd_data = {{(32-CHANNELS){1'b0}}, level_reg};
                `OFS_NOW:   rd_data = now_reg;
                default:    rd_err  = 1'b1;
            endcase
        end
    end

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pready    <= 1'b0;
            prdata    <= 32'h00000000;
            pslverr   <= 1'b0;
            stamp_reg <= 32'h00000000;
            level_reg <= {CHANNELS{1'b0}};
        end else begin
            pready    <= bus_req;
            level_reg <= pwm_in;
            if (bus_req) begin
                prdata  <= pwrite ? 32'h00000000 : rd_data;
                pslverr <= rd_err;
            end else if (!psel) begin
                pslverr <= 1'b0;
            end
            if (acq) begin
                stamp_reg <= now_reg;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : chan
            localparam [7:0] IDX = g;
            reg  [7:0]  cfg_reg;
            reg  [31:0] tout_reg;
            reg  [31:0] dflt_reg;
            reg  [31:0] result_reg;
            reg         in_reg;
            reg  [31:0] rise_ts_reg;
            reg  [31:0] rise_prev_reg;
            reg  [31:0] fall_ts_reg;
            reg  [31:0] fall_prev_reg;
            reg  [31:0] hi_w_reg;
            reg  [31:0] lo_w_reg;
            reg  [31:0] add_hi_reg;
            reg  [31:0] add_lo_reg;
            reg  [31:0] rise_cnt_reg;
            reg  [31:0] fall_cnt_reg;
            reg  [31:0] result_next;
            wire        wr_hit;
            wire        rise;
            wire        fall;
            wire [4:0]  method;
            wire [1:0]  tmode;
            wire        edge_fall;
            wire [31:0] period;
            wire [31:0] since;
            wire [31:0] div_p;
            wire [31:0] div_s;
            wire        timeout;
            wire        inpdep;
            wire [47:0] freq_q;
            wire [47:0] since_q;
            wire [47:0] duty_lo_q;
            wire [47:0] duty_hi_q;

            assign wr_hit    = bus_wr & ch_sel & (ch_idx == IDX);
            assign rise      = pwm_in[g] & ~in_reg;
            assign fall      = ~pwm_in[g] & in_reg;
            assign method    = cfg_reg[`CFG_METHOD_HI:0];
            assign tmode     = cfg_reg[`CFG_TMODE_HI:`CFG_TMODE_LO];
            assign edge_fall = cfg_reg[`CFG_EDGE_BIT];
            // period ended by the latest active edge
            assign period = edge_fall ? fall_ts_reg - fall_prev_reg
                                      : rise_ts_reg - rise_prev_reg;
            assign since  = edge_fall ? now_reg - fall_ts_reg
                                      : now_reg - rise_ts_reg;
            // guard against divide by zero before the first active edge, and for since in the tick of an edge
            assign div_p  = (period == 32'h0) ? 32'h1 : period;
            assign div_s  = (since == 32'h0) ? 32'h1 : since;
            // stamps start at zero, so a silent input times out
            assign timeout = (tmode != `TMODE_OFF) &&
                             ((now_reg - rise_ts_reg > tout_reg) ||
                              (now_reg - rise_prev_reg > tout_reg) ||
                              (now_reg - fall_ts_reg > tout_reg) ||
                              (now_reg - fall_prev_reg > tout_reg));
            assign inpdep  = (tmode == `TMODE_INPDEP);
            assign freq_q    = FREQ_NUM / {16'h0000, div_p};
            assign since_q   = FREQ_NUM / {16'h0000, div_s};
            assign duty_lo_q = {lo_w_reg, `DUTY_SHIFT} / {16'h0000, div_p};
            assign duty_hi_q = {hi_w_reg, `DUTY_SHIFT} / {16'h0000, div_p};

            always @* begin
                result_next = 32'h00000000;
                case (method)
                    `M_HIGH:        result_next = hi_w_reg;
                    `M_LOW:         result_next = lo_w_reg;
                    `M_ADD_HIGH:    result_next = add_hi_reg;
                    `M_ADD_LOW:     result_next = add_lo_reg;
                    `M_LOW_PULSES:  result_next = rise_cnt_reg;
                    `M_HIGH_PULSES: result_next = fall_cnt_reg;
                    `M_RISE_EDGES:  result_next = rise_cnt_reg;
                    `M_FALL_EDGES:  result_next = fall_cnt_reg;
                    `M_CYCLE:       result_next = period;
                    `M_FREQ:        result_next = freq_q[31:0];
                    `M_DUTY_LOW:    result_next = duty_lo_q[31:0];
                    `M_DUTY_HIGH:   result_next = duty_hi_q[31:0];
                    `M_LEVEL_HIGH:  result_next = {31'h0, in_reg};
                    `M_LEVEL_LOW:   result_next = {31'h0, ~in_reg};
                    default:        result_next = 32'h00000000;
                endcase
                if (timeout && !inpdep) begin
                    result_next = dflt_reg;
                end else if (timeout) begin
                    case (method)
                        `M_CYCLE:     result_next = since;
                        `M_FREQ:      result_next = since_q[31:0];
                        `M_DUTY_LOW:  result_next = in_reg ? 32'h0
                                                  : `DUTY_ONE;
                        `M_DUTY_HIGH: result_next = in_reg ? `DUTY_ONE
                                                  : 32'h0;
                        default:      result_next = 32'h00000000;
                    endcase
                end
                if (method == `M_NONE) begin
                    result_next = 32'h00000000;
                end
            end

            always @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    cfg_reg       <= 8'h00;
                    tout_reg      <= 32'h00000000;
                    dflt_reg      <= 32'h00000000;
                    result_reg    <= 32'h00000000;
                    in_reg        <= 1'b0;
                    rise_ts_reg   <= 32'h00000000;
                    rise_prev_reg <= 32'h00000000;
                    fall_ts_reg   <= 32'h00000000;
                    fall_prev_reg <= 32'h00000000;
                    hi_w_reg      <= 32'h00000000;
                    lo_w_reg      <= 32'h00000000;
                    add_hi_reg    <= 32'h00000000;
                    add_lo_reg    <= 32'h00000000;
                    rise_cnt_reg  <= 32'h00000000;
                    fall_cnt_reg  <= 32'h00000000;
                end else begin
                    in_reg <= pwm_in[g];
                    if (wr_hit && ch_ofs == `CH_CFG) begin
                        cfg_reg <= pwdata[7:0];
                    end
                    if (wr_hit && ch_ofs == `CH_TOUT) begin
                        tout_reg <= pwdata;
                    end
                    if (wr_hit && ch_ofs == `CH_DFLT) begin
                        dflt_reg <= pwdata;
                    end
                    if (rise) begin
                        rise_prev_reg <= rise_ts_reg;
                        rise_ts_reg   <= now_reg;
                        lo_w_reg      <= now_reg - fall_ts_reg;
                    end
                    if (fall) begin
                        fall_prev_reg <= fall_ts_reg;
                        fall_ts_reg   <= now_reg;
                        hi_w_reg      <= now_reg - rise_ts_reg;
                    end
                    // an edge in the strobe cycle opens the next interval
                    if (acq) begin
                        result_reg   <= result_next;
                        add_hi_reg   <= {31'h0, tick & in_reg};
                        add_lo_reg   <= {31'h0, tick & ~in_reg};
                        rise_cnt_reg <= {31'h0, rise};
                        fall_cnt_reg <= {31'h0, fall};
                    end else begin
                        add_hi_reg   <= add_hi_reg +
                                        {31'h0, tick & in_reg};
                        add_lo_reg   <= add_lo_reg +
                                        {31'h0, tick & ~in_reg};
                        rise_cnt_reg <= rise_cnt_reg + {31'h0, rise};
                        fall_cnt_reg <= fall_cnt_reg + {31'h0, fall};
                    end
                end
            end

            assign cfg_flat[g*32 +: 32]  = {24'h000000, cfg_reg};
            assign tout_flat[g*32 +: 32] = tout_reg;
            assign dflt_flat[g*32 +: 32] = dflt_reg;
            assign res_flat[g*32 +: 32]  = result_reg;
        end
    endgenerate
endmodule // pwm_input_measurement_unit

// file: design/pwm_meas_defines.vh
// constants of the pwm input measurement unit
`ifndef PWM_MEAS_DEFINES_VH
`define PWM_MEAS_DEFINES_VH
`define CLK_NS        10
`define TICK_NS       20
`define NS_PER_S      1000000000
`define ADDR_W        12
`define OFS_CTRL      12'h000
`define OFS_STAMP     12'h004
`define OFS_LEVEL     12'h008
`define OFS_NOW       12'h00C
`define CH_BASE_IDX   8'h10
`define CH_CFG        2'h0
`define CH_TOUT       2'h1
`define CH_DFLT       2'h2
`define CH_RESULT     2'h3
`define CTRL_ACQ_BIT  0
`define CFG_METHOD_HI 4
`define CFG_EDGE_BIT  5
`define CFG_TMODE_HI  7
`define CFG_TMODE_LO  6
`define TMODE_OFF     2'h0
`define TMODE_PREDEF  2'h1
`define TMODE_INPDEP  2'h2
`define M_NONE        5'h00
`define M_HIGH        5'h01
`define M_LOW         5'h02
`define M_ADD_HIGH    5'h03
`define M_ADD_LOW     5'h04
`define M_LOW_PULSES  5'h05
`define M_HIGH_PULSES 5'h06
`define M_RISE_EDGES  5'h07
`define M_FALL_EDGES  5'h08
`define M_CYCLE       5'h09
`define M_FREQ        5'h0A
`define M_DUTY_LOW    5'h0B
`define M_DUTY_HIGH   5'h0C
`define M_LEVEL_HIGH  5'h0D
`define M_LEVEL_LOW   5'h0E
`define M_STEP_A      5'h0F
`define M_STEP_B      5'h10
`define DUTY_ONE      32'h00010000
`define DUTY_SHIFT    16'h0000
`endif

// file: testbench/pwm_meas_properties.sv
// apb-side assertions for the pwm input measurement unit
`timescale 1ns/1ps
`include "pwm_meas_defines.vh"
module pwm_meas_properties #(
    parameter CHANNELS = 24
) (
    input wire logic                clock,
    input wire logic                reset_n,
    input wire logic [CHANNELS-1:0] pwm_in,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic                pready,
    input wire logic [31:0]         prdata,
    input wire logic                pslverr
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_one_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_qualified: assert property (pready |-> psel && penable)
        else $error("pready outside an access");
    a_data_hold: assert property (!pready |-> $stable(prdata))
        else $error("read data moved between answers");
    a_err_hold: assert property (!pready && $past(psel) |-> $stable(pslverr))
        else $error("error flag moved between answers");
    a_unmapped_err: assert property (pready && !pwrite && paddr == 12'hFFC
        |-> pslverr && prdata == 32'h00000000)
        else $error("unmapped read not refused");
    a_mapped_ok: assert property (pready && paddr < 12'h010 |-> !pslverr)
        else $error("error on a mapped register");
    a_ctrl_zero: assert property (pready && !pwrite && paddr == `OFS_CTRL
        |-> prdata == 32'h00000000)
        else $error("control register read not zero");
endmodule // pwm_meas_properties
bind pwm_input_measurement_unit pwm_meas_properties #(.CHANNELS(CHANNELS))
    u_props (.clock(clock), .reset_n(reset_n), .pwm_in(pwm_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));

// file: testbench/pwm_source.sv
// stand-in for the digitised sensor signal feeding every channel
`timescale 1ns/1ps
module pwm_source #(
    parameter HIGH_CLK = 20,
    parameter LOW_CLK  = 30
) (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic run,
    output logic      pwm
);
    int cnt;
    // changes only after a clock edge, like a synchronised sensor line
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 0;
            pwm <= 1'b0;
        end else if (!run) begin
            cnt <= 0;
            pwm <= 1'b1; // stalled sensor parks high
        end else begin
            cnt <= (cnt == HIGH_CLK + LOW_CLK - 1) ? 0 : cnt + 1;
            pwm <= (cnt < HIGH_CLK);
        end
    end
endmodule // pwm_source

// file: testbench/pwm_input_measurement_unit_tb_top.sv
// self-checking bench for the pwm input measurement unit
`timescale 1ns/1ps
`include "pwm_meas_defines.vh"
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
    n_mismatch++; $display("unexpected at %0t got %h exp %h", $time, got, exp); end end
module pwm_input_measurement_unit_tb_top;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        run = 1'b0;
    logic        pwm;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [31:0] rdata;
    logic        rerr;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    always #5 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    pwm_source u_src (.clock(clock), .reset_n(reset_n), .run(run), .pwm(pwm));
    pwm_input_measurement_unit #(.CHANNELS(8)) uut (.clock(clock),
        .reset_n(reset_n), .pwm_in({8{pwm}}), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr));
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) n_mismatch++;
        rdata = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [11:0] ch_addr(int n, int r);
        return 12'h100 + 12'(16 * n + 4 * r);
    endfunction
    // two strobes exactly four source periods apart, then read all results
    task automatic measure(input logic [63:0] cfgs, input logic [255:0] exp);
        int t0;
        int t1;
        for (int n = 0; n < 8; n++) apb(1'b1, ch_addr(n, 0), {24'h0, cfgs[8*n+:8]});
        repeat (200) @(posedge clock);
        t0 = cyc;
        apb(1'b1, `OFS_CTRL, 32'h00000001);
        t1 = cyc;
        while (cyc != t1 + 200 - (t1 - t0)) @(posedge clock);
        apb(1'b1, `OFS_CTRL, 32'h00000001);
        for (int n = 0; n < 8; n++) begin
            apb(1'b0, ch_addr(n, 3), 32'h0);
            `CHECK(rdata, exp[32*n+:32])
        end
    endtask
    task automatic test_regs;
        apb(1'b0, ch_addr(2, 0), 32'h0);
        `CHECK(rdata, 32'h00000000)
        apb(1'b1, ch_addr(2, 1), 32'h00000064);
        apb(1'b0, ch_addr(2, 1), 32'h0);
        `CHECK(rdata, 32'h00000064)
        apb(1'b0, 12'hFFC, 32'h0);
        `CHECK({rerr, rdata}, 33'h100000000)
        apb(1'b0, `OFS_CTRL, 32'h0);
        `CHECK({rerr, rdata}, 33'h000000000)
    endtask
    // high 10 ticks, low 15 ticks: times, sums and counts over 4 periods
    task automatic test_times_counts;
        measure(64'h0807060504030201, {32'h4, 32'h4, 32'h4, 32'h4, 32'h3C,
            32'h28, 32'hF, 32'hA});
    endtask
    // period 25 ticks on either edge, frequency, duty, idle methods
    task automatic test_period_duty;
        measure(64'h100F000C0B0A2909, {32'h0, 32'h0, 32'h0, 32'h6666,
            32'h9999, 32'h1E8480, 32'h19, 32'h19});
    endtask
    // source parks high; timeout of 100 ticks exceeds the 25 tick period
    task automatic test_timeout;
        for (int n = 0; n < 8; n++) apb(1'b1, ch_addr(n, 1), 32'h00000064);
        apb(1'b1, ch_addr(5, 2), 32'h00001234);
        for (int n = 0; n < 8; n++)
            apb(1'b1, ch_addr(n, 0), {24'h0, 8'(64'h0E0D4A8C8B8A8981 >> (8 * n))});
        run <= 1'b0;
        repeat (400) @(posedge clock);
        apb(1'b1, `OFS_CTRL, 32'h00000001);
        apb(1'b0, ch_addr(0, 3), 32'h0);
        `CHECK(rdata, 32'h00000000)
        apb(1'b0, ch_addr(1, 3), 32'h0);
        `CHECK(rdata > 32'd100, 1'b1)
        apb(1'b0, ch_addr(2, 3), 32'h0);
        `CHECK(rdata > 0 && rdata < 32'd500000, 1'b1)
        apb(1'b0, ch_addr(3, 3), 32'h0);
        `CHECK(rdata, 32'h00000000)
        apb(1'b0, ch_addr(4, 3), 32'h0);
        `CHECK(rdata, 32'h00010000)
        apb(1'b0, ch_addr(5, 3), 32'h0);
        `CHECK(rdata, 32'h00001234)
        apb(1'b0, ch_addr(6, 3), 32'h0);
        `CHECK(rdata, 32'h00000001)
        apb(1'b0, ch_addr(7, 3), 32'h0);
        `CHECK(rdata, 32'h00000000)
        apb(1'b0, `OFS_LEVEL, 32'h0);
        `CHECK(rdata, 32'h000000FF)
    endtask
    task automatic final_report;
        $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        test_regs();
        run <= 1'b1;
        test_times_counts();
        test_period_duty();
        test_timeout();
        final_report();
    end
endmodule // pwm_input_measurement_unit_tb_top
